//--- pafs_board.sv
`timescale 1ns/1ps
module pafs_board
    import pafs_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire pafs_pin_drive_t p0Drive,
    input  wire pafs_pin_drive_t p1Drive,
    input  wire pafs_pin_drive_t p3Drive,
    input  wire logic [7:0]      ext0,
    input  wire logic [7:0]      ext1,
    input  wire logic [7:0]      ext3,
    input  wire pafs_from_pins_t fromPins,
    input  wire logic            useRx,
    output logic [7:0]           p0PinIn,
    output logic [7:0]           p1PinIn,
    output logic [7:0]           p3PinIn,
    output logic                 rxEnable,
    output logic                 irq7Hit
);
    logic irq7Prev;

    // Undriven pins follow the board's own levels
    assign p0PinIn = (p0Drive.enable & p0Drive.level) | (~p0Drive.enable & ext0);
    assign p1PinIn = (p1Drive.enable & p1Drive.level) | (~p1Drive.enable & ext1);
    assign p3PinIn = (p3Drive.enable & p3Drive.level) | (~p3Drive.enable & ext3);
    assign rxEnable = useRx;

    // Edge detect only while the shared pin is not the receive input
    always_ff @(posedge clk_sys) begin
        irq7Prev <= fromPins.externalIrq7;
        irq7Hit  <= !useRx && fromPins.externalIrq7 && !irq7Prev;
    end
endmodule

//--- pafs_defs.svh
`ifndef PAFS_DEFS_SVH
`define PAFS_DEFS_SVH

`define PAFS_OFS_P0_LATCH    8'h00
`define PAFS_OFS_P0_DIR      8'h04
`define PAFS_OFS_P0_MODE     8'h08
`define PAFS_OFS_P0_FSEL     8'h0c
`define PAFS_OFS_P0_FEXT     8'h10
`define PAFS_OFS_P1_LATCH    8'h14
`define PAFS_OFS_P1_DIR      8'h18
`define PAFS_OFS_P3_LATCH    8'h1c
`define PAFS_OFS_P3_DIR      8'h20
`define PAFS_OFS_P3_MODE     8'h24
`define PAFS_OFS_P3_FSEL     8'h28
`define PAFS_OFS_P3_FEXT     8'h2c
`define PAFS_OFS_DEBUG       8'h30
`define PAFS_OFS_P0_LEVEL    8'h34
`define PAFS_OFS_P1_LEVEL    8'h38
`define PAFS_OFS_P3_LEVEL    8'h3c

`define PAFS_RST_PORT        8'h00
`define PAFS_RST_DEBUG       1'b0

`define PAFS_P0_MODE_MASK    8'h7c
`define PAFS_P0_FSEL_MASK    8'h1c
`define PAFS_P0_FEXT_MASK    8'h18
`define PAFS_P3_MODE_MASK    8'h0f
`define PAFS_P3_FSEL_MASK    8'h0f
`define PAFS_P3_FEXT_MASK    8'h04
`define PAFS_P1_ANALOG_MASK  8'h03

`define PAFS_BIT_NMI         2
`define PAFS_BIT_IRQ0        3
`define PAFS_BIT_IRQ1        4
`define PAFS_BIT_IRQ2        5
`define PAFS_BIT_IRQ3        6
`define PAFS_BIT_TXD         0
`define PAFS_BIT_RXD         1
`define PAFS_BIT_SCK         2
`define PAFS_BIT_TMR1        3

`define PAFS_SEL_00          2'b00
`define PAFS_SEL_01          2'b01
`define PAFS_SEL_10          2'b10
`define PAFS_SEL_11          2'b11

`define PAFS_HTRANS_NONSEQ   2'b10
`define PAFS_RX_IDLE         1'b1

`endif

//--- pafs_pkg.sv
package pafs_pkg;

    // Signals from on-chip peripherals towards the pins
    typedef struct packed {
        logic oneHertzClockOut;
        logic clockDividerOutput;
        logic clockCalibrationOutput;
        logic asyncTransmitOut;
        logic clockedSerialOutCh4;
        logic clockedSerialClockCh4Out;
        logic clockedSerialClockCh4Oe;
        logic timerOut0;
        logic timerOut1;
    } pafs_to_pins_t;

    // Signals from the pins towards on-chip peripherals
    typedef struct packed {
        logic nmiInput;
        logic upperAddressBit21;
        logic externalIrq0;
        logic converterTriggerInput;
        logic externalIrq1;
        logic externalIrq2;
        logic debugResetInput;
        logic externalIrq3;
        logic asyncReceiveIn;
        logic externalIrq7;
        logic clockedSerialInCh4;
        logic asyncSerialClockIn;
        logic clockedSerialClockCh4In;
        logic timerCaptureIn0;
        logic timerCaptureIn1;
    } pafs_from_pins_t;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } pafs_pin_drive_t;

endpackage

//--- pafs_port_alternate_function_select.sv
// Operation
// RULE1: Alternate routing only when mode bit is 1; latch and direction then ignored.
// RULE2: NMI pin with mode 1: select 0 gives NMI, 1 gives address bit 21.
// RULE3: Port 0 pin 3: 00 irq0, 01 converter trigger, 11 one-hertz clock.
// RULE4: Port 0 pin 4: 00 irq1, 01 divider output, 10 calibration output.
// RULE5: Port 0 pin 5: mode 1 gives irq2; debug takeover forces debug reset.
// RULE6: Port 0 pin 6: mode 1 gives irq3, no select bits.
// RULE7: Port 1 pins 0,1 present analog outputs when direction bit is 1.
// RULE8: Software keeps neighbour port level steady during analog output.
// RULE9: Port 3 pin 0 mode 1: select 0 transmit, 1 channel 4 data out.
// RULE10: Port 3 pin 1 mode 1: select 0 receive and irq7, 1 channel 4 in.
// RULE11: Software disables irq7 edge detection while pin serves as receive input.
// RULE12: Software disables the receiver while pin serves as irq7.
// RULE13: Port 3 pin 2: 00 async clock, 01 ch4 clock, 10 capture0, 11 timer0.
// RULE14: Port 3 pin 3 mode 1: select 0 capture1, select 1 timer output 1.
// RULE15: Mode bit 0: plain port, direction enables driver, latch gives level.
`timescale 1ns/1ps
`include "pafs_defs.svh"

module pafs_port_alternate_function_select
    import pafs_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            sys_rst,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic [31:0]          hrdata,
    input  wire logic [7:0]      p0PinIn,
    input  wire logic [7:0]      p1PinIn,
    input  wire logic [7:0]      p3PinIn,
    output pafs_pin_drive_t      p0Drive,
    output pafs_pin_drive_t      p1Drive,
    output pafs_pin_drive_t      p3Drive,
    output logic [1:0]           analogOutEnable,
    input  wire pafs_to_pins_t   toPins,
    output pafs_from_pins_t      fromPins
);

    logic [7:0]      p0Latch;
    logic [7:0]      p0Dir;
    logic [7:0]      p0Mode;
    logic [7:0]      p0Fsel;
    logic [7:0]      p0Fext;
    logic [7:0]      p1Latch;
    logic [7:0]      p1Dir;
    logic [7:0]      p3Latch;
    logic [7:0]      p3Dir;
    logic [7:0]      p3Mode;
    logic [7:0]      p3Fsel;
    logic [7:0]      p3Fext;
    logic            debugTakeover;
    logic            wrPend;
    logic [7:0]      wrAddr;
    logic [23:0]     pinMeta;
    logic [23:0]     pinSync;
    logic [7:0]      p0Level;
    logic [7:0]      p1Level;
    logic [7:0]      p3Level;
    logic            addrPhase;
    logic [7:0]      wrData;
    logic [7:0]      next_p0Latch;
    logic [7:0]      next_p0Dir;
    logic [7:0]      next_p0Mode;
    logic [7:0]      next_p0Fsel;
    logic [7:0]      next_p0Fext;
    logic [7:0]      next_p1Latch;
    logic [7:0]      next_p1Dir;
    logic [7:0]      next_p3Latch;
    logic [7:0]      next_p3Dir;
    logic [7:0]      next_p3Mode;
    logic [7:0]      next_p3Fsel;
    logic [7:0]      next_p3Fext;
    logic            next_debugTakeover;
    logic [7:0]      next_readData;
    pafs_pin_drive_t next_p0Drive;
    pafs_pin_drive_t next_p1Drive;
    pafs_pin_drive_t next_p3Drive;
    pafs_from_pins_t next_fromPins;

    // Pins are asynchronous to clk_sys: two flops before any use
    genvar gi;
    generate
        for (gi = 0; gi < 24; gi++) begin : gSync
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    pinMeta[gi] <= 1'b0;
                    pinSync[gi] <= 1'b0;
                end else begin
                    pinMeta[gi] <= (gi < 8) ? p0PinIn[gi % 8] :
                                   (gi < 16) ? p1PinIn[gi % 8] : p3PinIn[gi % 8];
                    pinSync[gi] <= pinMeta[gi];
                end
            end
        end
    endgenerate

    assign p0Level = pinSync[7:0];
    assign p1Level = pinSync[15:8];
    assign p3Level = pinSync[23:16];

    assign addrPhase = hsel && hready && (htrans == `PAFS_HTRANS_NONSEQ);
    assign wrData    = hwdata[7:0];

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else if (hready) begin
            wrPend <= addrPhase && hwrite;
            wrAddr <= haddr[7:0];
        end
    end

    // Register write decode; unused select bits are held at zero
    always_comb begin
        next_p0Latch       = p0Latch;
        next_p0Dir         = p0Dir;
        next_p0Mode        = p0Mode;
        next_p0Fsel        = p0Fsel;
        next_p0Fext        = p0Fext;
        next_p1Latch       = p1Latch;
        next_p1Dir         = p1Dir;
        next_p3Latch       = p3Latch;
        next_p3Dir         = p3Dir;
        next_p3Mode        = p3Mode;
        next_p3Fsel        = p3Fsel;
        next_p3Fext        = p3Fext;
        next_debugTakeover = debugTakeover;
        if (wrPend) begin
            case (wrAddr)
                `PAFS_OFS_P0_LATCH: next_p0Latch = wrData;
                `PAFS_OFS_P0_DIR:   next_p0Dir   = wrData;
                `PAFS_OFS_P0_MODE:  next_p0Mode  = wrData & `PAFS_P0_MODE_MASK;
                `PAFS_OFS_P0_FSEL:  next_p0Fsel  = wrData & `PAFS_P0_FSEL_MASK;
                `PAFS_OFS_P0_FEXT:  next_p0Fext  = wrData & `PAFS_P0_FEXT_MASK;
                `PAFS_OFS_P1_LATCH: next_p1Latch = wrData;
                `PAFS_OFS_P1_DIR:   next_p1Dir   = wrData;
                `PAFS_OFS_P3_LATCH: next_p3Latch = wrData;
                `PAFS_OFS_P3_DIR:   next_p3Dir   = wrData;
                `PAFS_OFS_P3_MODE:  next_p3Mode  = wrData & `PAFS_P3_MODE_MASK;
                `PAFS_OFS_P3_FSEL:  next_p3Fsel  = wrData & `PAFS_P3_FSEL_MASK;
                `PAFS_OFS_P3_FEXT:  next_p3Fext  = wrData & `PAFS_P3_FEXT_MASK;
                `PAFS_OFS_DEBUG:    next_debugTakeover = wrData[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            p0Latch       <= `PAFS_RST_PORT;
            p0Dir         <= `PAFS_RST_PORT;
            p0Mode        <= `PAFS_RST_PORT;
            p0Fsel        <= `PAFS_RST_PORT;
            p0Fext        <= `PAFS_RST_PORT;
            p1Latch       <= `PAFS_RST_PORT;
            p1Dir         <= `PAFS_RST_PORT;
            p3Latch       <= `PAFS_RST_PORT;
            p3Dir         <= `PAFS_RST_PORT;
            p3Mode        <= `PAFS_RST_PORT;
            p3Fsel        <= `PAFS_RST_PORT;
            p3Fext        <= `PAFS_RST_PORT;
            debugTakeover <= `PAFS_RST_DEBUG;
        end else begin
            p0Latch       <= next_p0Latch;
            p0Dir         <= next_p0Dir;
            p0Mode        <= next_p0Mode;
            p0Fsel        <= next_p0Fsel;
            p0Fext        <= next_p0Fext;
            p1Latch       <= next_p1Latch;
            p1Dir         <= next_p1Dir;
            p3Latch       <= next_p3Latch;
            p3Dir         <= next_p3Dir;
            p3Mode        <= next_p3Mode;
            p3Fsel        <= next_p3Fsel;
            p3Fext        <= next_p3Fext;
            debugTakeover <= next_debugTakeover;
        end
    end

    // Read mux uses next_ values so a write just before a read is seen
    always_comb begin
        case (haddr[7:0])
            `PAFS_OFS_P0_LATCH: next_readData = next_p0Latch;
            `PAFS_OFS_P0_DIR:   next_readData = next_p0Dir;
            `PAFS_OFS_P0_MODE:  next_readData = next_p0Mode;
            `PAFS_OFS_P0_FSEL:  next_readData = next_p0Fsel;
            `PAFS_OFS_P0_FEXT:  next_readData = next_p0Fext;
            `PAFS_OFS_P1_LATCH: next_readData = next_p1Latch;
            `PAFS_OFS_P1_DIR:   next_readData = next_p1Dir;
            `PAFS_OFS_P3_LATCH: next_readData = next_p3Latch;
            `PAFS_OFS_P3_DIR:   next_readData = next_p3Dir;
            `PAFS_OFS_P3_MODE:  next_readData = next_p3Mode;
            `PAFS_OFS_P3_FSEL:  next_readData = next_p3Fsel;
            `PAFS_OFS_P3_FEXT:  next_readData = next_p3Fext;
            `PAFS_OFS_DEBUG:    next_readData = {7'h00, next_debugTakeover};
            `PAFS_OFS_P0_LEVEL: next_readData = p0Level;
            `PAFS_OFS_P1_LEVEL: next_readData = p1Level;
            `PAFS_OFS_P3_LEVEL: next_readData = p3Level;
            default:            next_readData = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= {24'h00_0000, next_readData};
        end
    end

    // Pin selection
    always_comb begin
        next_fromPins = '0;
        next_fromPins.asyncReceiveIn = `PAFS_RX_IDLE;
        next_p0Drive.level  = p0Latch; // see RULE15
        next_p0Drive.enable = p0Dir & ~p0Mode; // see RULE15 see RULE1
        next_p1Drive.level  = p1Latch; // see RULE15
        next_p1Drive.enable = p1Dir & ~`PAFS_P1_ANALOG_MASK; // see RULE7
        next_p3Drive.level  = p3Latch; // see RULE15
        next_p3Drive.enable = p3Dir & ~p3Mode; // see RULE15 see RULE1
        if (p0Mode[`PAFS_BIT_NMI]) begin // see RULE2
            if (p0Fsel[`PAFS_BIT_NMI]) begin
                next_fromPins.upperAddressBit21 = p0Level[`PAFS_BIT_NMI];
            end else begin
                next_fromPins.nmiInput = p0Level[`PAFS_BIT_NMI];
            end
        end
        if (p0Mode[`PAFS_BIT_IRQ0]) begin // see RULE3
            case ({p0Fext[`PAFS_BIT_IRQ0], p0Fsel[`PAFS_BIT_IRQ0]})
                `PAFS_SEL_00: next_fromPins.externalIrq0 = p0Level[`PAFS_BIT_IRQ0];
                `PAFS_SEL_01: next_fromPins.converterTriggerInput = p0Level[`PAFS_BIT_IRQ0];
                `PAFS_SEL_11: begin
                    next_p0Drive.level[`PAFS_BIT_IRQ0]  = toPins.oneHertzClockOut;
                    next_p0Drive.enable[`PAFS_BIT_IRQ0] = 1'b1;
                end
                default: ;
            endcase
        end
        if (p0Mode[`PAFS_BIT_IRQ1]) begin // see RULE4
            case ({p0Fext[`PAFS_BIT_IRQ1], p0Fsel[`PAFS_BIT_IRQ1]})
                `PAFS_SEL_00: next_fromPins.externalIrq1 = p0Level[`PAFS_BIT_IRQ1];
                `PAFS_SEL_01: begin
                    next_p0Drive.level[`PAFS_BIT_IRQ1]  = toPins.clockDividerOutput;
                    next_p0Drive.enable[`PAFS_BIT_IRQ1] = 1'b1;
                end
                `PAFS_SEL_10: begin
                    next_p0Drive.level[`PAFS_BIT_IRQ1]  = toPins.clockCalibrationOutput;
                    next_p0Drive.enable[`PAFS_BIT_IRQ1] = 1'b1;
                end
                default: ;
            endcase
        end
        // Debug takeover wins over every port bit of this pin
        if (debugTakeover) begin // see RULE5
            next_fromPins.debugResetInput       = p0Level[`PAFS_BIT_IRQ2];
            next_p0Drive.enable[`PAFS_BIT_IRQ2] = 1'b0;
        end else if (p0Mode[`PAFS_BIT_IRQ2]) begin
            next_fromPins.externalIrq2 = p0Level[`PAFS_BIT_IRQ2];
        end
        if (p0Mode[`PAFS_BIT_IRQ3]) begin // see RULE6
            next_fromPins.externalIrq3 = p0Level[`PAFS_BIT_IRQ3];
        end
        if (p3Mode[`PAFS_BIT_TXD]) begin // see RULE9
            next_p3Drive.enable[`PAFS_BIT_TXD] = 1'b1;
            next_p3Drive.level[`PAFS_BIT_TXD]  = p3Fsel[`PAFS_BIT_TXD] ?
                toPins.clockedSerialOutCh4 : toPins.asyncTransmitOut;
        end
        // Receiver and irq7 both see the pin; software silences one of them
        if (p3Mode[`PAFS_BIT_RXD]) begin // see RULE10 see RULE11 see RULE12
            if (p3Fsel[`PAFS_BIT_RXD]) begin
                next_fromPins.clockedSerialInCh4 = p3Level[`PAFS_BIT_RXD];
            end else begin
                next_fromPins.asyncReceiveIn = p3Level[`PAFS_BIT_RXD];
                next_fromPins.externalIrq7   = p3Level[`PAFS_BIT_RXD];
            end
        end
        if (p3Mode[`PAFS_BIT_SCK]) begin // see RULE13
            case ({p3Fext[`PAFS_BIT_SCK], p3Fsel[`PAFS_BIT_SCK]})
                `PAFS_SEL_00: next_fromPins.asyncSerialClockIn = p3Level[`PAFS_BIT_SCK];
                `PAFS_SEL_01: begin
                    next_fromPins.clockedSerialClockCh4In = p3Level[`PAFS_BIT_SCK];
                    next_p3Drive.level[`PAFS_BIT_SCK]  = toPins.clockedSerialClockCh4Out;
                    next_p3Drive.enable[`PAFS_BIT_SCK] = toPins.clockedSerialClockCh4Oe;
                end
                `PAFS_SEL_10: next_fromPins.timerCaptureIn0 = p3Level[`PAFS_BIT_SCK];
                default: begin
                    next_p3Drive.level[`PAFS_BIT_SCK]  = toPins.timerOut0;
                    next_p3Drive.enable[`PAFS_BIT_SCK] = 1'b1;
                end
            endcase
        end
        if (p3Mode[`PAFS_BIT_TMR1]) begin // see RULE14
            if (p3Fsel[`PAFS_BIT_TMR1]) begin
                next_p3Drive.level[`PAFS_BIT_TMR1]  = toPins.timerOut1;
                next_p3Drive.enable[`PAFS_BIT_TMR1] = 1'b1;
            end else begin
                next_fromPins.timerCaptureIn1 = p3Level[`PAFS_BIT_TMR1];
            end
        end
    end

    // Registered outputs cost one cycle of latency but keep pins glitch free
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            p0Drive         <= '0;
            p1Drive         <= '0;
            p3Drive         <= '0;
            analogOutEnable <= 2'b00;
            fromPins        <= '{asyncReceiveIn: `PAFS_RX_IDLE, default: 1'b0};
        end else begin
            p0Drive         <= next_p0Drive;
            p1Drive         <= next_p1Drive;
            p3Drive         <= next_p3Drive;
            analogOutEnable <= p1Dir[1:0]; // see RULE7
            fromPins        <= next_fromPins;
        end
    end

endmodule

//--- pafs_port_alternate_function_select_asserts.sv
`timescale 1ns/1ps
module pafs_chk
    import pafs_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            sys_rst,
    input  wire logic            hreadyout,
    input  wire logic            hresp,
    input  wire logic [31:0]     hrdata,
    input  wire logic [7:0]      p0PinIn,
    input  wire logic [7:0]      p3PinIn,
    input  wire pafs_pin_drive_t p0Drive,
    input  wire pafs_pin_drive_t p1Drive,
    input  wire pafs_pin_drive_t p3Drive,
    input  wire logic [1:0]      analogOutEnable,
    input  wire pafs_from_pins_t fromPins
);
    logic [1:0] upCnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // Pin pipeline is three flops deep, so wait that long after reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            upCnt <= 2'd0;
        end else if (upCnt != 2'd3) begin
            upCnt <= upCnt + 2'd1;
        end
    end

    a_ready_up: assert property (1'b1 |=> hreadyout && !hresp && hrdata[31:8] == 24'h0)
        else $error("bus answer not ready or not okay");
    a_reset_quiet: assert property ($past(sys_rst) |->
        p0Drive == '0 && p1Drive == '0 && p3Drive == '0 && $countones(fromPins) == 1 &&
        fromPins.asyncReceiveIn)
        else $error("outputs not cleared by reset");
    a_analog_nodrive: assert property (p1Drive.enable[1:0] == 2'b00)
        else $error("analog capable pin driven digitally");
    a_nmi_excl: assert property (fromPins.nmiInput || fromPins.upperAddressBit21 |->
        !(fromPins.nmiInput && fromPins.upperAddressBit21) && $past(p0PinIn[2], 3))
        else $error("nmi or address input wrong");
    a_irq3_pin: assert property (fromPins.externalIrq3 |-> $past(p0PinIn[6], 3))
        else $error("irq3 high without pin high");
    a_rx_pin: assert property (upCnt == 2'd3 && !fromPins.asyncReceiveIn |->
        !$past(p3PinIn[1], 3))
        else $error("receive input low without pin low");
    a_irq7_rx: assert property (fromPins.externalIrq7 |->
        fromPins.asyncReceiveIn && $past(p3PinIn[1], 3))
        else $error("irq7 and receive input disagree");
    a_debug_over: assert property (fromPins.debugResetInput |->
        !fromPins.externalIrq2 && $past(p0PinIn[5], 3))
        else $error("debug reset input wrong");
    a_clock_excl: assert property ($onehot0({fromPins.asyncSerialClockIn,
        fromPins.clockedSerialClockCh4In, fromPins.timerCaptureIn0}))
        else $error("several port3 pin2 inputs fed");

    c_debug: cover property (fromPins.debugResetInput);
    c_irq7: cover property (fromPins.externalIrq7);
    c_analog: cover property (analogOutEnable == 2'b11);
endmodule

bind pafs_port_alternate_function_select pafs_chk i_pafs_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .p0PinIn(p0PinIn), .p3PinIn(p3PinIn), .p0Drive(p0Drive),
    .p1Drive(p1Drive), .p3Drive(p3Drive), .analogOutEnable(analogOutEnable),
    .fromPins(fromPins));

//--- tb_port_alternate_function_select.sv
`timescale 1ns/1ps
`include "pafs_defs.svh"
module tb_port_alternate_function_select
    import pafs_pkg::*;
;
    logic            clk_sys = 1'b0;
    logic            sys_rst = 1'b1;
    logic            hsel = 1'b0;
    logic            hwrite = 1'b0;
    logic [1:0]      htrans = 2'b00;
    logic [31:0]     haddr = 32'h0;
    logic [31:0]     hwdata = 32'h0;
    logic            hreadyout, hresp;
    logic [31:0]     hrdata, rd;
    logic [31:0]     rnd = 32'h71ae6b9d;
    logic [7:0]      p0PinIn, p1PinIn, p3PinIn;
    logic [7:0]      ext0 = 8'h00, ext1 = 8'h00, ext3 = 8'h00;
    pafs_pin_drive_t p0Drive, p1Drive, p3Drive;
    logic [1:0]      analogOutEnable;
    pafs_to_pins_t   toPins = '0;
    pafs_from_pins_t fromPins;
    logic            useRx = 1'b0;
    logic [7:0]      r [13];
    logic [7:0]      qp [3];
    logic [7:0]      msk [13] = '{8'hff, 8'hff, 8'h7c, 8'h1c, 8'h18, 8'hff, 8'hff,
                                  8'hff, 8'hff, 8'h0f, 8'h0f, 8'h04, 8'h01};
    int              errors = 0, samples_checked = 0, cyc = 0;

    pafs_port_alternate_function_select i_pafs_port_alternate_function_select (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .p0PinIn(p0PinIn),
        .p1PinIn(p1PinIn), .p3PinIn(p3PinIn), .p0Drive(p0Drive), .p1Drive(p1Drive),
        .p3Drive(p3Drive), .analogOutEnable(analogOutEnable), .toPins(toPins),
        .fromPins(fromPins));
    pafs_board i_pafs_board (
        .clk_sys(clk_sys), .p0Drive(p0Drive), .p1Drive(p1Drive), .p3Drive(p3Drive),
        .ext0(ext0), .ext1(ext1), .ext3(ext3), .fromPins(fromPins), .useRx(useRx),
        .p0PinIn(p0PinIn), .p1PinIn(p1PinIn), .p3PinIn(p3PinIn), .rxEnable(), .irq7Hit());

    always #2.5 clk_sys = ~clk_sys;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic give_verdict;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // Holds each phase until hready is seen high at an edge, for at most 50 edges
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= `PAFS_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hwdata <= d;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
    endtask

    task automatic verify;
        logic [7:0]      e0, l0, e1, e3, l3, m, m3, f3;
        logic [1:0]      s3, s4, s2;
        pafs_from_pins_t ef;
        m = r[2];
        m3 = r[9];
        f3 = r[10];
        s3 = {r[4][3], r[3][3]};
        s4 = {r[4][4], r[3][4]};
        s2 = {r[11][2], f3[2]};
        e0 = r[1] & ~m;
        l0 = r[0];
        e1 = r[6] & 8'hfc;
        e3 = r[8] & ~m3;
        l3 = r[7];
        if (m[3] && s3 == 2'b11) {e0[3], l0[3]} = {1'b1, toPins.oneHertzClockOut};
        if (m[4] && s4 == 2'b01) {e0[4], l0[4]} = {1'b1, toPins.clockDividerOutput};
        if (m[4] && s4 == 2'b10) {e0[4], l0[4]} = {1'b1, toPins.clockCalibrationOutput};
        if (r[12][0]) e0[5] = 1'b0;
        if (m3[0]) begin
            e3[0] = 1'b1;
            l3[0] = f3[0] ? toPins.clockedSerialOutCh4 : toPins.asyncTransmitOut;
        end
        if (m3[2] && s2 == 2'b01) begin
            e3[2] = toPins.clockedSerialClockCh4Oe;
            l3[2] = toPins.clockedSerialClockCh4Out;
        end
        if (m3[2] && s2 == 2'b11) {e3[2], l3[2]} = {1'b1, toPins.timerOut0};
        if (m3[3] && f3[3]) {e3[3], l3[3]} = {1'b1, toPins.timerOut1};
        qp[0] = (e0 & l0) | (~e0 & ext0);
        qp[1] = (e1 & r[5]) | (~e1 & ext1);
        qp[2] = (e3 & l3) | (~e3 & ext3);
        ef = '0;
        ef.asyncReceiveIn = 1'b1;
        if (m[2] && r[3][2]) ef.upperAddressBit21 = qp[0][2];
        if (m[2] && !r[3][2]) ef.nmiInput = qp[0][2];
        if (m[3] && s3 == 2'b00) ef.externalIrq0 = qp[0][3];
        if (m[3] && s3 == 2'b01) ef.converterTriggerInput = qp[0][3];
        if (m[4] && s4 == 2'b00) ef.externalIrq1 = qp[0][4];
        if (r[12][0]) ef.debugResetInput = qp[0][5];
        else if (m[5]) ef.externalIrq2 = qp[0][5];
        if (m[6]) ef.externalIrq3 = qp[0][6];
        if (m3[1] && f3[1]) ef.clockedSerialInCh4 = qp[2][1];
        if (m3[1] && !f3[1]) {ef.asyncReceiveIn, ef.externalIrq7} = {2{qp[2][1]}};
        if (m3[2] && s2 == 2'b00) ef.asyncSerialClockIn = qp[2][2];
        if (m3[2] && s2 == 2'b01) ef.clockedSerialClockCh4In = qp[2][2];
        if (m3[2] && s2 == 2'b10) ef.timerCaptureIn0 = qp[2][2];
        if (m3[3] && !f3[3]) ef.timerCaptureIn1 = qp[2][3];
        check("p0 enable", 32'(p0Drive.enable), 32'(e0));
        check("p0 level", 32'(p0Drive.level & e0), 32'(l0 & e0));
        check("p1 enable", 32'(p1Drive.enable), 32'(e1));
        check("p1 level", 32'(p1Drive.level & e1), 32'(r[5] & e1));
        check("analog", 32'(analogOutEnable), 32'(r[6][1:0]));
        check("p3 enable", 32'(p3Drive.enable), 32'(e3));
        check("p3 level", 32'(p3Drive.level & e3), 32'(l3 & e3));
        check("from pins", 32'(fromPins), 32'(ef));
        bus(1'b1, 8'h34, 32'hffff_ffff);
        for (int i = 0; i < 17; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            check("register", rd, i < 13 ? {24'h0, r[i]} : i < 16 ? {24'h0, qp[i - 13]} : 0);
        end
    endtask

    initial begin
        for (int i = 0; i < 13; i++) r[i] = 8'h00;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        verify();
        for (int it = 0; it < 80; it++) begin
            for (int i = 0; i < 13; i++) begin
                rnd = lfsr(rnd);
                if (i == 5) rnd[1:0] = 2'b00;
                bus(1'b1, 8'(i * 4), rnd);
                r[i] = rnd[7:0] & msk[i];
            end
            rnd = lfsr(rnd);
            @(posedge clk_sys);
            toPins <= rnd[8:0];
            ext0 <= rnd[31:24];
            ext1 <= rnd[23:16];
            ext3 <= rnd[15:8];
            useRx <= !r[10][1];
            repeat (8) @(posedge clk_sys);
            verify();
        end
        give_verdict();
    end
endmodule
